// >>> src/ddac_device.sv
// Device end: serial frame decoder, double-buffered DAC registers, power modes
`timescale 1ns/100ps
// What this block does
// (R1) Command 100 is power down or up
// (R2) Mode bits DB5:DB4 pick output termination
// (R3) Mode applies to channels selected by DB1:DB0
// (R4) Normal mode code powers selected channels up
// (R5) Power-up resumes input value if strobe low
// (R6) Power-down keeps DAC register contents
// (R7) Host waits about 4 us after power-up
// (R8) Complete frame writes addressed input register
// (R9) Strobe high holds DAC registers except for mask-bit writes and software update commands
// (R10) Strobe low copies input to DAC registers
// (R11) Copy only channels changed since last update
// (R12) Synchronous style updates after 24th edge
// (R13) Asynchronous style updates on strobe falling
// (R14) Mask bit set updates its channel on every frame that writes it
// (R15) Command 110 loads update mask
// (R16) Update mask resets to zero
// (R17) Power frame: command, mode, selects; rest ignored
// (R18) Data shifts on falling clock, executes at 24
// (R19) Frame: 2 spare, command, address, 16 data
// (R20) Decode all write and update command codes
// (R21) Early sync rise discards the frame
// (R22) Keep per-channel power mode, reset normal
// (R23) Pending flag gates strobe-driven transfers
module ddac_device (
  input wire logic pclk,
  input wire logic presetn,
  ddac_link_if.dev link,
  output logic [15:0] dac_a_q,
  output logic [15:0] dac_b_q,
  output logic [1:0] mode_a_q,
  output logic [1:0] mode_b_q,
  output logic [1:0] channel_update_mask_q
);
  logic fs_n;
  logic sck;
  logic sdi;
  logic ld_n;
  logic sck_q;
  logic [23:0] shift_q;
  logic [4:0] count_q;
  logic done_q;
  logic [23:0] frame_q;
  logic [15:0] in_a_q;
  logic [15:0] in_b_q;
  logic [1:0] pend_q;
  logic [1:0] pend_d;
  logic [1:0] in_wr;
  logic [1:0] upd;
  logic [1:0] soft_upd;
  logic [23:0] word;
  logic fall;
  logic exec;
  logic [2:0] cmd;
  logic [2:0] adr;
  logic [1:0] hit;

  // Every pin crosses two flops before use
  // Clock and data share the same delay, so data is seen as it stood at the clock's fall
  ddac_sync2 #(.RESET_VAL(1'b1)) u_fs (.pclk(pclk), .presetn(presetn), .async_in(link.frame_sync_n),
    .sync_out(fs_n));
  ddac_sync2 #(.RESET_VAL(1'b1)) u_sck (.pclk(pclk), .presetn(presetn), .async_in(link.serial_clk),
    .sync_out(sck));
  ddac_sync2 #(.RESET_VAL(1'b0)) u_sdi (.pclk(pclk), .presetn(presetn), .async_in(link.serial_data),
    .sync_out(sdi));
  ddac_sync2 #(.RESET_VAL(1'b1)) u_ld (.pclk(pclk), .presetn(presetn), .async_in(link.load_strobe_n),
    .sync_out(ld_n));

  // Edge history of the sampled serial clock; resets to the idle level
  // so that the first sample after reset cannot look like a falling edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_q <= 1'b1;
    end else begin
      sck_q <= sck;
    end
  end

  assign fall = sck_q && !sck && !fs_n;
  assign word = {shift_q[22:0], sdi};

  // Shift on falling clock; sync high clears the frame
  // Falls after the 24th are ignored until sync rises; the count stops at a full frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_q <= 24'h000000;
      count_q <= 5'h00;
      done_q <= 1'b0;
      frame_q <= 24'h000000;
    end else begin
      done_q <= 1'b0;
      if (fs_n) begin
        shift_q <= 24'h000000; // see (R21)
        count_q <= 5'h00;
      end else if (fall && count_q != 5'(ddac_pkg::FRAME_BITS)) begin
        shift_q <= word; // see (R18)
        count_q <= count_q + 5'h01;
        if (count_q == 5'(ddac_pkg::FRAME_BITS - 1)) begin
          frame_q <= word; // see (R18)
          done_q <= 1'b1;
        end
      end
    end
  end

  // Decode the captured frame (see (R19))
  assign exec = done_q;
  assign cmd = frame_q[ddac_pkg::CMD_HI:ddac_pkg::CMD_LO];
  assign adr = frame_q[ddac_pkg::ADDR_HI:ddac_pkg::ADDR_LO];
  assign hit = {adr == ddac_pkg::ADDR_B || adr == ddac_pkg::ADDR_ALL,
                adr == ddac_pkg::ADDR_A || adr == ddac_pkg::ADDR_ALL};

  // Reset and reserved frames fall to the default branch and change nothing;
  // power and mask frames are handled by their own registers further down
  always_comb begin
    in_wr = 2'h0;
    soft_upd = 2'h0;
    if (exec) begin
      case (cmd)
        ddac_pkg::CMD_WRITE_IN: in_wr = hit; // see (R8)
        ddac_pkg::CMD_UPDATE: soft_upd = hit; // see (R20)
        ddac_pkg::CMD_WRITE_ALL: begin
          in_wr = hit;
          soft_upd = 2'h3;
        end
        ddac_pkg::CMD_WRITE_UPD: begin
          in_wr = hit;
          soft_upd = hit;
        end
        default: begin
          in_wr = 2'h0;
          soft_upd = 2'h0;
        end
      endcase
    end
  end

  // Input registers take the data word of a valid write
  // Only channels named by the address field are written; other codes write nothing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_a_q <= ddac_pkg::DAC_RESET;
      in_b_q <= ddac_pkg::DAC_RESET;
    end else begin
      if (in_wr[0]) in_a_q <= frame_q[15:0]; // see (R8)
      if (in_wr[1]) in_b_q <= frame_q[15:0];
    end
  end

  // Update causes: strobe low, or masked channel after a frame, or software
  // Hardware transfers need a pending change; software commands force one
  // The strobe is a level: held low it keeps copying any channel that turns pending
  always_comb begin
    upd = soft_upd;
    for (int i = 0; i < 2; i++) begin
      if (!ld_n && (pend_q[i] || in_wr[i])) upd[i] = 1'b1; // see (R10) (R11) (R12) (R13) (R23)
      if (channel_update_mask_q[i] && in_wr[i]) upd[i] = 1'b1; // see (R14)
    end
  end

  // Pending flags: set by a write, cleared by an update
  // A write that updates in the same cycle leaves nothing pending, as the DAC took the word
  always_comb begin
    pend_d = (pend_q & ~upd) | (in_wr & ~upd);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 2'h0;
    end else begin
      pend_q <= pend_d; // see (R23)
    end
  end

  // DAC registers hold unless updated; power state never touches them
  // A write in an update cycle passes the frame word straight on, beside the input register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_a_q <= ddac_pkg::DAC_RESET;
      dac_b_q <= ddac_pkg::DAC_RESET;
    end else begin
      if (upd[0]) dac_a_q <= in_wr[0] ? frame_q[15:0] : in_a_q; // see (R9) (R6)
      if (upd[1]) dac_b_q <= in_wr[1] ? frame_q[15:0] : in_b_q;
    end
  end

  // Power command applies the mode to the selected channels only
  // Modes drive the output termination select: 00 normal, 01 1k, 10 100k, 11 three-state
  // On power-up a channel shows its held DAC value with the strobe high, or its input
  // value with the strobe low, since the strobe path above has already copied it (see (R5))
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_a_q <= ddac_pkg::DDAC_MODE_NORMAL; // see (R22)
      mode_b_q <= ddac_pkg::DDAC_MODE_NORMAL;
    end else if (exec && cmd == ddac_pkg::CMD_POWER) begin // see (R1)
      if (frame_q[ddac_pkg::SEL_A]) mode_a_q <= frame_q[ddac_pkg::MODE_HI:ddac_pkg::MODE_LO]; // see (R2) (R3) (R4)
      if (frame_q[ddac_pkg::SEL_B]) mode_b_q <= frame_q[ddac_pkg::MODE_HI:ddac_pkg::MODE_LO];
    end
  end

  // Update mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      channel_update_mask_q <= ddac_pkg::MASK_RESET; // see (R16)
    end else if (exec && cmd == ddac_pkg::CMD_MASK) begin
      channel_update_mask_q <= frame_q[ddac_pkg::SEL_B:ddac_pkg::SEL_A]; // see (R15)
    end
  end
endmodule

// >>> src/ddac_host.sv
// Host end: APB-programmed serial frame sender with load strobe control
`timescale 1ns/100ps
module ddac_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  ddac_link_if.host link
);
  typedef enum logic [2:0] {
    DDAC_IDLE = 3'b001,
    DDAC_SEND = 3'b010,
    DDAC_GAP = 3'b100
  } ddac_hstate_t;
  ddac_hstate_t state_q;
  logic [23:0] tx_q;
  logic [5:0] edge_q;
  logic [2:0] div_q;
  logic [31:0] ctrl_q;
  logic go;
  logic acc;
  logic sent_q;

  assign acc = psel && penable;
  assign go = acc && pwrite && paddr == ddac_pkg::REG_FRAME && state_q == DDAC_IDLE;

  // APB answer: one access cycle, unmapped address errors, frame writes while busy error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (psel && !penable) begin
        case (paddr)
          ddac_pkg::REG_FRAME: pslverr <= pwrite && state_q != DDAC_IDLE;
          ddac_pkg::REG_CTRL: prdata <= ctrl_q;
          ddac_pkg::REG_STATUS: prdata <= {30'h00000000, sent_q, state_q != DDAC_IDLE};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Control register: strobe level and abort request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 32'h00000001;
    end else if (acc && pready && pwrite && paddr == ddac_pkg::REG_CTRL) begin
      ctrl_q <= pwdata;
    end else if (state_q != DDAC_SEND) begin
      ctrl_q[ddac_pkg::CTRL_ABORT] <= 1'b0;
    end
  end

  // Frame engine: clock idles high, data changes on rising edge, device samples falling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= DDAC_IDLE;
      tx_q <= 24'h000000;
      edge_q <= 6'h00;
      div_q <= 3'h0;
      sent_q <= 1'b0;
      link.frame_sync_n <= 1'b1;
      link.serial_clk <= 1'b1;
      link.serial_data <= 1'b0;
    end else begin
      case (state_q)
        DDAC_IDLE: begin
          if (go && pready) begin
            tx_q <= pwdata[23:0];
            link.serial_data <= pwdata[23];
            link.frame_sync_n <= 1'b0; // see (R18)
            edge_q <= 6'h00;
            div_q <= 3'h0;
            sent_q <= 1'b0;
            state_q <= DDAC_SEND;
          end
        end
        DDAC_SEND: begin
          if (ctrl_q[ddac_pkg::CTRL_ABORT]) begin
            link.frame_sync_n <= 1'b1; // see (R21)
            link.serial_clk <= 1'b1;
            // Restart the divider so the gap after a cut frame is a full half period
            div_q <= 3'h0;
            state_q <= DDAC_GAP;
          end else if (div_q == 3'(ddac_pkg::SCLK_HALF - 1)) begin
            div_q <= 3'h0;
            edge_q <= edge_q + 6'h01;
            link.serial_clk <= ~link.serial_clk;
            if (!link.serial_clk) begin
              tx_q <= {tx_q[22:0], 1'b0};
              link.serial_data <= tx_q[22]; // see (R17) (R19)
            end
            if (edge_q == 6'(2 * ddac_pkg::FRAME_BITS - 1)) begin
              link.frame_sync_n <= 1'b1;
              sent_q <= 1'b1;
              state_q <= DDAC_GAP;
            end
          end else begin
            div_q <= div_q + 3'h1;
          end
        end
        DDAC_GAP: begin
          div_q <= div_q + 3'h1;
          if (div_q == 3'(ddac_pkg::SCLK_HALF - 1)) state_q <= DDAC_IDLE;
        end
        default: state_q <= DDAC_IDLE;
      endcase
    end
  end

  // Load strobe follows software level (see (R12) (R13))
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.load_strobe_n <= 1'b1;
    end else begin
      link.load_strobe_n <= ctrl_q[ddac_pkg::CTRL_LOAD_N];
    end
  end
endmodule

// >>> src/ddac_link_if.sv
// Interface: serial frame pins and load strobe between host and device
`timescale 1ns/100ps
interface ddac_link_if;
  logic frame_sync_n;
  logic serial_clk;
  logic serial_data;
  logic load_strobe_n;
  modport host (output frame_sync_n, output serial_clk, output serial_data, output load_strobe_n);
  modport dev (input frame_sync_n, input serial_clk, input serial_data, input load_strobe_n);
endinterface

// >>> src/ddac_pkg.sv
// Package: frame layout, command codes, modes, timing and host register map
package ddac_pkg;
  localparam int FRAME_BITS = 24;
  localparam int CMD_HI = 21;
  localparam int CMD_LO = 19;
  localparam int ADDR_HI = 18;
  localparam int ADDR_LO = 16;
  localparam int MODE_HI = 5;
  localparam int MODE_LO = 4;
  localparam int SEL_B = 1;
  localparam int SEL_A = 0;
  localparam logic [2:0] CMD_WRITE_IN = 3'h0;
  localparam logic [2:0] CMD_UPDATE = 3'h1;
  localparam logic [2:0] CMD_WRITE_ALL = 3'h2;
  localparam logic [2:0] CMD_WRITE_UPD = 3'h3;
  localparam logic [2:0] CMD_POWER = 3'h4;
  localparam logic [2:0] CMD_RESET = 3'h5;
  localparam logic [2:0] CMD_MASK = 3'h6;
  localparam logic [2:0] ADDR_A = 3'h0;
  localparam logic [2:0] ADDR_B = 3'h1;
  localparam logic [2:0] ADDR_ALL = 3'h7;
  typedef enum logic [1:0] {
    DDAC_MODE_NORMAL = 2'h0,
    DDAC_MODE_1K = 2'h1,
    DDAC_MODE_100K = 2'h2,
    DDAC_MODE_TRI = 2'h3
  } ddac_mode_t;
  localparam logic [1:0] MASK_RESET = 2'h0;
  localparam logic [15:0] DAC_RESET = 16'h0000;
  // Power-up settling time the host must respect, in ns
  localparam int WAKE_NS = 4000;
  localparam int CLK_NS = 10;
  localparam int WAKE_CYC = (WAKE_NS + CLK_NS - 1) / CLK_NS;
  // Serial clock half period in pclk cycles
  localparam int SCLK_HALF = 4;
  // Host APB map
  localparam logic [7:0] REG_FRAME = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam int CTRL_LOAD_N = 0;
  localparam int CTRL_ABORT = 1;
  localparam int CTRL_AT = 8;
  localparam logic [4:0] CTRL_AT_RESET = 5'h00;
endpackage

// >>> src/ddac_sync2.sv
// Two-flop synchroniser for one pin
`timescale 1ns/100ps
module ddac_sync2 #(
  parameter logic RESET_VAL = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;
  // First flop feeds only the second; both reset to the pin's idle level
  // so that no false edge is seen when reset is released
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// >>> tb/ddac_link_props.sv
// Checker: timing and framing of the serial link between host and device
`timescale 1ns/100ps
module ddac_link_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic frame_sync_n,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic load_strobe_n
);
  logic [5:0] fall_cnt_q;
  // Falling serial clock edges seen in the current frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fall_cnt_q <= 6'h00;
    end else if (frame_sync_n) begin
      fall_cnt_q <= 6'h00;
    end else if ($fell(serial_clk)) begin
      fall_cnt_q <= fall_cnt_q + 6'h01;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Link pins come out of reset idle
  rst_idle_a: assert property ($rose(presetn) |-> frame_sync_n && serial_clk && load_strobe_n)
    else $error("link not idle after reset");
  clk_idle_a: assert property (frame_sync_n |-> serial_clk)
    else $error("serial clock not high outside a frame");
  // An abort may cut a half period short, so a raised sync excuses it
  half_per_a: assert property ($changed(serial_clk) |=> ($stable(serial_clk) || frame_sync_n) [*3])
    else $error("serial clock half period too short");
  sync_gap_a: assert property ($rose(frame_sync_n) |=> frame_sync_n [*3])
    else $error("frame gap too short");
  data_fall_a: assert property ($fell(serial_clk) |-> $stable(serial_data))
    else $error("data moved on the sampling edge");
  data_low_a: assert property (!serial_clk && !$past(serial_clk) && !frame_sync_n |-> $stable(serial_data))
    else $error("data moved while clock low");
  fall_cnt_a: assert property (fall_cnt_q <= 6'h18)
    else $error("more than a frame of clock falls");
  fall_frame_a: assert property ($fell(serial_clk) |-> !frame_sync_n)
    else $error("clock fell outside a frame");
  full_frame_c: cover property ($rose(frame_sync_n) && fall_cnt_q == 6'h18);
  cut_frame_c: cover property ($rose(frame_sync_n) && fall_cnt_q < 6'h18 && fall_cnt_q != 6'h00);
  strobe_low_c: cover property ($fell(load_strobe_n));
endmodule

// >>> tb/tb_dual_dac_powerdown_load_control.sv
// Testbench: host and device joined over the serial link, driven through APB
`timescale 1ns/100ps
module tb_dual_dac_powerdown_load_control;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] dac_a, dac_b;
  logic [1:0] mode_a, mode_b, mask;
  logic [31:0] rd;
  logic err;
  int bad_count = 0;
  int compares = 0;
  ddac_link_if i_ddac_link_if ();
  ddac_host i_ddac_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(i_ddac_link_if.host));
  ddac_device i_ddac_device (.pclk(pclk), .presetn(presetn), .link(i_ddac_link_if.dev), .dac_a_q(dac_a),
    .dac_b_q(dac_b), .mode_a_q(mode_a), .mode_b_q(mode_b), .channel_update_mask_q(mask));
  ddac_link_props i_ddac_link_props (.pclk(pclk), .presetn(presetn), .frame_sync_n(i_ddac_link_if.frame_sync_n),
    .serial_clk(i_ddac_link_if.serial_clk), .serial_data(i_ddac_link_if.serial_data),
    .load_strobe_n(i_ddac_link_if.load_strobe_n));
  // 100 MHz clock
  always #5 pclk = ~pclk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data and error are taken at the pready edge
  // The waits have no limit of their own: the watchdog ends a hung transfer
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Polls status until the sender is idle, then lets the device act
  task automatic wait_idle();
    do begin
      apb(1'b0, ddac_pkg::REG_STATUS, 32'h00000000);
    end while (rd[0] !== 1'b0);
    repeat (6) @(posedge pclk);
  endtask
  task automatic frame(input logic [2:0] c, input logic [2:0] a, input logic [15:0] d);
    apb(1'b1, ddac_pkg::REG_FRAME, {8'h00, 2'b00, c, a, d});
    wait_idle();
  endtask
  // Strobe level passes two synchroniser flops, hence the settle wait
  task automatic strobe(input logic v);
    apb(1'b1, ddac_pkg::REG_CTRL, {30'h00000000, 1'b0, v});
    repeat (6) @(posedge pclk);
  endtask
  task automatic t_reset();
    chk(mask, 2'h0);
    chk({mode_a, mode_b, dac_a}, 20'h00000);
    chk(dac_b, 16'h0000);
    apb(1'b0, ddac_pkg::REG_CTRL, 32'h00000000);
    chk(rd[0], 1'b1);
    apb(1'b0, 8'h40, 32'h00000000);
    chk(err, 1'b1);
    chk(rd, 32'h00000000);
    $display("test reset done");
  endtask
  task automatic t_strobe();
    frame(3'h0, 3'h0, 16'h1234);
    chk(dac_a, 16'h0000);
    strobe(1'b0);
    chk({dac_a, dac_b}, 32'h12340000);
    frame(3'h0, 3'h1, 16'h5A5A);
    chk(dac_b, 16'h5A5A);
    strobe(1'b1);
    frame(3'h0, 3'h0, 16'hBEEF);
    chk(dac_a, 16'h1234);
    $display("test strobe done");
  endtask
  // Address field carries junk that the power command must ignore
  task automatic t_power();
    for (int m = 1; m < 4; m++) begin
      frame(3'h4, 3'h5, {10'h000, m[1:0], 2'b00, 2'b01});
      chk({mode_a, mode_b, dac_a}, {m[1:0], 2'b00, 16'h1234});
    end
    frame(3'h4, 3'h0, {10'h000, 2'b10, 2'b00, 2'b10});
    chk({mode_a, mode_b}, 4'hE);
    frame(3'h4, 3'h0, 16'h0003);
    // Output is only trusted once the wake time has passed
    repeat (ddac_pkg::WAKE_CYC) @(posedge pclk);
    chk({mode_a, mode_b, dac_a}, 20'h01234);
    $display("test power done");
  endtask
  task automatic t_mask();
    frame(3'h6, 3'h0, 16'h0002);
    chk(mask, 2'h2);
    frame(3'h0, 3'h1, 16'h0F0F);
    chk({dac_a, dac_b}, 32'h12340F0F);
    frame(3'h6, 3'h0, 16'h0000);
    chk(mask, 2'h0);
    $display("test mask done");
  endtask
  task automatic t_cmds();
    frame(3'h1, 3'h0, 16'h0000);
    chk(dac_a, 16'hBEEF);
    frame(3'h3, 3'h1, 16'h1111);
    chk(dac_b, 16'h1111);
    frame(3'h2, 3'h0, 16'h2222);
    chk({dac_a, dac_b}, 32'h22221111);
    frame(3'h0, 3'h7, 16'h3333);
    strobe(1'b0);
    strobe(1'b1);
    frame(3'h5, 3'h7, 16'h0001);
    frame(3'h7, 3'h7, 16'h0000);
    chk({dac_a, dac_b}, 32'h33333333);
    chk({mask, mode_a, mode_b}, 6'h00);
    $display("test commands done");
  endtask
  // Abort mid-frame; a second frame write while busy is refused
  task automatic t_abort();
    apb(1'b1, ddac_pkg::REG_FRAME, {8'h00, 2'b00, 3'h3, 3'h0, 16'h4444});
    apb(1'b1, ddac_pkg::REG_FRAME, 32'h00000000);
    chk(err, 1'b1);
    repeat (40) @(posedge pclk);
    apb(1'b1, ddac_pkg::REG_CTRL, 32'h00000003);
    wait_idle();
    chk(rd[1], 1'b0);
    chk(dac_a, 16'h3333);
    frame(3'h3, 3'h0, 16'h4444);
    chk(rd[1], 1'b1);
    chk(dac_a, 16'h4444);
    $display("test abort done");
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_strobe();
    t_power();
    t_mask();
    t_cmds();
    t_abort();
    test_done();
  end
  // Watchdog well beyond the roughly 4300 cycles the tests need
  initial begin
    repeat (50000) @(posedge pclk);
    bad_count++;
    test_done();
  end
endmodule
